// ==== hdl/serial_mode_clock_select.sv ====
// Wire-mode pin control, clock source selection, shift register and counter.
//
// Our own choices: the register offsets and the strobed register port.
`default_nettype none

// Functional notes
// - Mode zero: serial outputs, hold, start detector off.
// - Three-wire: shift output replaces port bit on pin.
// - Three-wire: input and clock pins stay ordinary.
// - Two-wire: open-collector lines, enabled by direction bits.
// - Data line low if shift bit or port zero.
// - Clock line low if port zero or start hold.
// - Two-wire: start detection holds clock until flag cleared.
// - Two-wire: pull-ups off, inputs unaffected.
// - Mode three also holds clock on counter wrap.
// - Inputs work in every mode, even outputs off.
// - External clock: latch opposite edge; internal: transparent.
// - Internal sources: software strobe, timer match.
// - External: edge select; counter both edges or toggle.
// - Software strobe shifts and counts, output same cycle.
// - Strobe shifts in input sampled one cycle earlier.
// - Both strobe bits read back as zero.
// - Toggle strobe inverts clock port bit always.
// - External with strobe set: toggle writes count.
// - Wrap flag set when counter goes fifteen to zero.
// - Data output comes from shift register bit seven.
module serial_mode_clock_select
  import serial_mode_clock_select_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic timer0_match_i,
  input wire logic serial_data_in_i,
  input wire logic serial_clock_pin_i,
  output logic data_out_pin_o,
  output logic data_out_pin_oe_n_o,
  output logic data_out_pin_pullup_o,
  output logic serial_data_in_o,
  output logic serial_data_in_oe_n_o,
  output logic serial_data_in_pullup_o,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_n_o,
  output logic serial_clock_pin_pullup_o
);

  // Ordinary port pin: drive the port bit when the direction is output,
  // else float with the pull-up following the port bit. Packed {out, oe_n, pullup}.
  function automatic logic [2:0] pin_normal(input logic port_bit, input logic dir_bit);
    pin_normal = {port_bit, ~dir_bit, ~dir_bit & port_bit};
  endfunction : pin_normal

  // Open-collector line: always drives zero, enabled only while pulling low.
  // A released line reads back whatever the bus pull-up and the peer make of it.
  function automatic logic [2:0] pin_open_drain(input logic dir_bit, input logic pull_low);
    pin_open_drain = {1'b0, ~(dir_bit & pull_low), 1'b0};
  endfunction : pin_open_drain

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. Logic reads only the second stage and the one after it;
  // the first stage may go metastable and feeds nothing else.

  // The chains reset low, but a line may idle high. Edges are ignored until
  // three real samples of the pins have passed, so no false edge follows reset.
  logic [2:0] sync_fill;
  logic di_meta;
  logic di_sync;
  logic di_prev;
  logic ck_meta;
  logic ck_sync;
  logic ck_prev;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_fill <= 3'h0;
      di_meta <= 1'b0;
      di_sync <= 1'b0;
      di_prev <= 1'b0;
      ck_meta <= 1'b0;
      ck_sync <= 1'b0;
      ck_prev <= 1'b0;
    end else begin
      sync_fill <= {sync_fill[1:0], 1'b1};
      di_meta <= serial_data_in_i;
      di_sync <= di_meta;
      di_prev <= di_sync;
      ck_meta <= serial_clock_pin_i;
      ck_sync <= ck_meta;
      ck_prev <= ck_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register state and serial engine.

  wire_mode_t wire_mode;
  logic clk_src_external;
  logic clk_src_edge_sel;
  // With an external source the clock strobe bit is not a strobe: it is kept
  // here and picks toggle writes, not pin edges, as the counter's clock.
  logic counter_sel;
  logic [2:0] port_a_output_reg;
  logic [2:0] port_a_direction_reg;
  logic [7:0] shift_data;
  logic out_latch;
  logic [3:0] counter;
  logic start_cond_flag;
  logic counter_wrap_flag;

  wire_mode_t next_wire_mode;
  logic next_clk_src_external;
  logic next_clk_src_edge_sel;
  logic next_counter_sel;
  logic [2:0] next_port_a_output_reg;
  logic [2:0] next_port_a_direction_reg;
  logic [7:0] next_shift_data;
  logic next_out_latch;
  logic [3:0] next_counter;
  logic next_start_cond_flag;
  logic next_counter_wrap_flag;

  logic wr_ctrl;
  logic wr_stat;
  logic ck_rise;
  logic ck_fall;
  logic shift_evt;
  logic count_evt;
  logic shift_bit;
  logic start_evt;
  logic latch_open;
  logic di_fall;

  always_comb begin
    wr_ctrl = reg_wr_i && (reg_addr_i == CTRL_ADDR);
    wr_stat = reg_wr_i && (reg_addr_i == STAT_ADDR);
    // Edges come from synchronised samples, so each level must last a cycle.
    ck_rise = ck_sync & ~ck_prev & sync_fill[2];
    ck_fall = ~ck_sync & ck_prev & sync_fill[2];
    di_fall = ~di_sync & di_prev & sync_fill[2];

    // Clock source decode. Inputs are always honoured, whatever the wire mode.
    // The software strobe and the timer shift in the older sample, so the bit
    // that stood on the pin before the strobe is the one that lands.
    shift_evt = 1'b0;
    count_evt = 1'b0;
    shift_bit = di_sync;
    unique case ({clk_src_external, clk_src_edge_sel})
      2'b00: begin
        shift_evt = wr_ctrl & reg_wdata_i[CTRL_CLK_STB];
        count_evt = shift_evt;
        shift_bit = di_prev;
      end
      2'b01: begin
        shift_evt = timer0_match_i;
        count_evt = timer0_match_i;
        shift_bit = di_prev;
      end
      2'b10, 2'b11: begin
        shift_evt = clk_src_edge_sel ? ck_fall : ck_rise;
        if (counter_sel) begin
          count_evt = wr_ctrl & reg_wdata_i[CTRL_TOG_STB];
        end else begin
          count_evt = ck_rise | ck_fall;
        end
      end
    endcase

    // Control register. Strobes are acted on and never stored as strobes.
    // The decode above uses the clock source already held, so a strobe in the
    // same write that changes the source still acts under the old source.
    next_wire_mode = wire_mode;
    next_clk_src_external = clk_src_external;
    next_clk_src_edge_sel = clk_src_edge_sel;
    next_counter_sel = counter_sel;
    if (wr_ctrl) begin
      next_wire_mode = wire_mode_t'(reg_wdata_i[CTRL_WM_HI:CTRL_WM_LO]);
      next_clk_src_external = reg_wdata_i[CTRL_CS_EXT];
      next_clk_src_edge_sel = reg_wdata_i[CTRL_CS_EDGE];
      next_counter_sel = reg_wdata_i[CTRL_CS_EXT] & reg_wdata_i[CTRL_CLK_STB];
    end

    next_port_a_output_reg = port_a_output_reg;
    if (reg_wr_i && (reg_addr_i == PORT_ADDR)) begin
      next_port_a_output_reg = reg_wdata_i[2:0];
    end
    // A toggle acts whatever the direction; the pin shows it only when driven.
    if (wr_ctrl && reg_wdata_i[CTRL_TOG_STB]) begin
      next_port_a_output_reg[PIN_CK] = ~port_a_output_reg[PIN_CK];
    end

    next_port_a_direction_reg = port_a_direction_reg;
    if (reg_wr_i && (reg_addr_i == DIR_ADDR)) begin
      next_port_a_direction_reg = reg_wdata_i[2:0];
    end

    // A write in the same cycle as a shift keeps the written value.
    next_shift_data = shift_data;
    if (reg_wr_i && (reg_addr_i == DATA_ADDR)) begin
      next_shift_data = reg_wdata_i;
    end else if (shift_evt) begin
      next_shift_data = {shift_data[6:0], shift_bit};
    end

    // With an external clock the latch is open only in the half period before
    // the sampling edge, so the output moves on the opposite edge.
    if (!clk_src_external) begin
      latch_open = 1'b1;
    end else begin
      latch_open = clk_src_edge_sel ? ck_sync : ~ck_sync;
    end
    next_out_latch = latch_open ? next_shift_data[7] : out_latch;

    // Counter: a software load wins over a count and raises no wrap.
    // The wrap flag is set by counting alone, so a load of fifteen is harmless.
    next_counter = counter;
    next_counter_wrap_flag = counter_wrap_flag;
    if (wr_stat && reg_wdata_i[STAT_WRAP]) begin
      next_counter_wrap_flag = 1'b0;
    end
    if (wr_stat) begin
      next_counter = reg_wdata_i[STAT_CNT_HI:0];
    end else if (count_evt) begin
      next_counter = counter + 4'h1;
      if (counter == CNT_MAX) begin
        next_counter_wrap_flag = 1'b1;
      end
    end

    // Start detector: a start condition in two-wire modes, any clock edge in
    // three-wire mode, nothing while the interface is off.
    unique case (wire_mode)
      WIRE_OFF: start_evt = 1'b0;
      WIRE_THREE: start_evt = ck_rise | ck_fall;
      WIRE_TWO, WIRE_TWO_HOLD: start_evt = di_fall & ck_sync;
    endcase
    next_start_cond_flag = start_cond_flag;
    if (wr_stat && reg_wdata_i[STAT_START]) begin
      next_start_cond_flag = 1'b0;
    end
    if (start_evt) begin
      next_start_cond_flag = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wire_mode <= WIRE_OFF;
      clk_src_external <= 1'b0;
      clk_src_edge_sel <= 1'b0;
      counter_sel <= 1'b0;
      port_a_output_reg <= PORT_RESET;
      port_a_direction_reg <= DIR_RESET;
      shift_data <= DATA_RESET;
      out_latch <= 1'b0;
      counter <= CNT_RESET;
      start_cond_flag <= 1'b0;
      counter_wrap_flag <= 1'b0;
    end else begin
      wire_mode <= next_wire_mode;
      clk_src_external <= next_clk_src_external;
      clk_src_edge_sel <= next_clk_src_edge_sel;
      counter_sel <= next_counter_sel;
      port_a_output_reg <= next_port_a_output_reg;
      port_a_direction_reg <= next_port_a_direction_reg;
      shift_data <= next_shift_data;
      out_latch <= next_out_latch;
      counter <= next_counter;
      start_cond_flag <= next_start_cond_flag;
      counter_wrap_flag <= next_counter_wrap_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drivers. Each pin is registered, so it follows its cause by one cycle.
  // Each pin is kept as {value, enable_n, pull-up} so one function sets a whole pin.

  logic [2:0] do_pin;
  logic [2:0] di_pin;
  logic [2:0] ck_pin;
  logic [2:0] next_do_pin;
  logic [2:0] next_di_pin;
  logic [2:0] next_ck_pin;
  logic scl_pull_low;

  always_comb begin
    next_do_pin = pin_normal(port_a_output_reg[PIN_DO], port_a_direction_reg[PIN_DO]);
    next_di_pin = pin_normal(port_a_output_reg[PIN_DI], port_a_direction_reg[PIN_DI]);
    next_ck_pin = pin_normal(port_a_output_reg[PIN_CK], port_a_direction_reg[PIN_CK]);
    // The clock line is held low while software still owes an answer: a pending
    // start flag, or in the holding mode a counter wrap. The peer's clock is
    // stretched until the flag is cleared.
    scl_pull_low = ~port_a_output_reg[PIN_CK] | start_cond_flag;
    if (wire_mode == WIRE_TWO_HOLD) begin
      scl_pull_low = scl_pull_low | counter_wrap_flag;
    end
    unique case (wire_mode)
      WIRE_OFF: begin
        // All three pins stay ordinary port pins, as set up above.
        next_do_pin = pin_normal(port_a_output_reg[PIN_DO],
                                 port_a_direction_reg[PIN_DO]);
      end
      WIRE_THREE: begin
        next_do_pin[2] = out_latch;
      end
      WIRE_TWO, WIRE_TWO_HOLD: begin
        next_di_pin = pin_open_drain(port_a_direction_reg[PIN_DI],
                                     ~out_latch | ~port_a_output_reg[PIN_DI]);
        next_ck_pin = pin_open_drain(port_a_direction_reg[PIN_CK], scl_pull_low);
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      do_pin <= 3'b010;
      di_pin <= 3'b010;
      ck_pin <= 3'b010;
    end else begin
      do_pin <= next_do_pin;
      di_pin <= next_di_pin;
      ck_pin <= next_ck_pin;
    end
  end

  assign data_out_pin_o = do_pin[2];
  assign data_out_pin_oe_n_o = do_pin[1];
  assign data_out_pin_pullup_o = do_pin[0];
  assign serial_data_in_o = di_pin[2];
  assign serial_data_in_oe_n_o = di_pin[1];
  assign serial_data_in_pullup_o = di_pin[0];
  assign serial_clock_pin_o = ck_pin[2];
  assign serial_clock_pin_oe_n_o = ck_pin[1];
  assign serial_clock_pin_pullup_o = ck_pin[0];

  ////////////////////////////////////////////////////////////////////////////////
  // Read port. Unmapped addresses read zero.
  // Read data stand one cycle only, so a stale value is never taken for a fresh one.

  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = RDATA_RESET;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        CTRL_ADDR: next_rdata = {2'b00, wire_mode, clk_src_external, clk_src_edge_sel,
                                 2'b00};
        PORT_ADDR: next_rdata = {5'h00, port_a_output_reg};
        DIR_ADDR: next_rdata = {5'h00, port_a_direction_reg};
        DATA_ADDR: next_rdata = shift_data;
        STAT_ADDR: next_rdata = {start_cond_flag, counter_wrap_flag, 2'b00, counter};
        PIN_ADDR: next_rdata = {5'h00, ck_sync, di_sync, 1'b0};
        default: next_rdata = RDATA_RESET;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= RDATA_RESET;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

endmodule : serial_mode_clock_select

`default_nettype wire

// ==== hdl/serial_mode_clock_select_pkg.sv ====
// Constants and types shared by the serial wire-mode and clock-select block.
`default_nettype none

package serial_mode_clock_select_pkg;

  // Register indices on the plain register port.
  localparam logic [2:0] CTRL_ADDR = 3'h0;
  localparam logic [2:0] PORT_ADDR = 3'h1;
  localparam logic [2:0] DIR_ADDR = 3'h2;
  localparam logic [2:0] DATA_ADDR = 3'h3;
  localparam logic [2:0] STAT_ADDR = 3'h4;
  localparam logic [2:0] PIN_ADDR = 3'h5;

  // Field positions of serial_interface_control.
  localparam int CTRL_WM_HI = 5;
  localparam int CTRL_WM_LO = 4;
  localparam int CTRL_CS_EXT = 3;
  localparam int CTRL_CS_EDGE = 2;
  localparam int CTRL_CLK_STB = 1;
  localparam int CTRL_TOG_STB = 0;

  // Bit positions of the three pins in the port and direction registers, and of DI and CK in the pin register.
  localparam int PIN_DO = 0;
  localparam int PIN_DI = 1;
  localparam int PIN_CK = 2;

  // Field positions of the status register.
  localparam int STAT_START = 7;
  localparam int STAT_WRAP = 6;
  localparam int STAT_CNT_HI = 3;

  // Values after reset, and the counter's top value.
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [2:0] PORT_RESET = 3'h0;
  localparam logic [2:0] DIR_RESET = 3'h0;
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic [3:0] CNT_MAX = 4'hf;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  typedef enum logic [1:0] {
    WIRE_OFF = 2'b00,
    WIRE_THREE = 2'b01,
    WIRE_TWO = 2'b10,
    WIRE_TWO_HOLD = 2'b11
  } wire_mode_t;

endpackage : serial_mode_clock_select_pkg

`default_nettype wire

// ==== bench/serial_mode_clock_select_asserts.sv ====
// Checker of pin behaviour for the serial wire-mode and clock-select block.
`default_nettype none
module serial_mode_clock_select_asserts
  import serial_mode_clock_select_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic timer0_match_i,
  input wire logic serial_data_in_i,
  input wire logic serial_clock_pin_i,
  input wire logic data_out_pin_o,
  input wire logic data_out_pin_oe_n_o,
  input wire logic data_out_pin_pullup_o,
  input wire logic serial_data_in_o,
  input wire logic serial_data_in_oe_n_o,
  input wire logic serial_data_in_pullup_o,
  input wire logic serial_clock_pin_o,
  input wire logic serial_clock_pin_oe_n_o,
  input wire logic serial_clock_pin_pullup_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Shadows of the software-written state; reset to zero keeps every pin ordinary.
  logic [1:0] mode, next_mode;
  logic [2:0] port, next_port, dir, next_dir;
  logic [1:0] quiet, next_quiet;
  logic steady;
  assign steady = quiet[1];
  always_comb begin
    next_mode = mode;
    next_port = port;
    next_dir = dir;
    next_quiet = (quiet == 2'h3) ? quiet : quiet + 2'h1;
    if (reg_wr_i) begin
      next_quiet = 2'h0;
      if (reg_addr_i == CTRL_ADDR) begin
        next_mode = reg_wdata_i[CTRL_WM_HI:CTRL_WM_LO];
        next_port[PIN_CK] = port[PIN_CK] ^ reg_wdata_i[CTRL_TOG_STB];
      end
      if (reg_addr_i == PORT_ADDR) next_port = reg_wdata_i[2:0];
      if (reg_addr_i == DIR_ADDR) next_dir = reg_wdata_i[2:0];
    end
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode <= 2'h0;
      port <= 3'h0;
      dir <= 3'h0;
      quiet <= 2'h0;
    end else begin
      mode <= next_mode;
      port <= next_port;
      dir <= next_dir;
      quiet <= next_quiet;
    end
  end
  AST_STROBES_READ_ZERO: assert property (
    $past(reg_rd_i) && $past(reg_addr_i) == CTRL_ADDR |-> reg_rdata_o[1:0] == 2'h0)
    else $error("control strobe bits read back nonzero");
  AST_OFF_DO_ORDINARY: assert property (
    steady && mode == WIRE_OFF |-> data_out_pin_o == port[PIN_DO] &&
    data_out_pin_oe_n_o == !dir[PIN_DO] &&
    data_out_pin_pullup_o == (!dir[PIN_DO] && port[PIN_DO]))
    else $error("output pin not ordinary with wire mode off");
  AST_THREE_DO_DIR: assert property (
    steady && mode == WIRE_THREE |-> data_out_pin_oe_n_o == !dir[PIN_DO] &&
    data_out_pin_pullup_o == (!dir[PIN_DO] && port[PIN_DO]))
    else $error("three-wire output pin direction or pull-up wrong");
  AST_THREE_DI_CK_ORDINARY: assert property (
    steady && mode == WIRE_THREE |-> serial_clock_pin_o == port[PIN_CK] &&
    serial_clock_pin_oe_n_o == !dir[PIN_CK] && serial_data_in_oe_n_o == !dir[PIN_DI])
    else $error("three-wire input or clock pin overridden");
  AST_TWO_NO_PULLUP: assert property (
    steady && mode[1] |-> !serial_data_in_pullup_o && !serial_clock_pin_pullup_o)
    else $error("pull-up active in two-wire mode");
  AST_TWO_OPEN_DRAIN: assert property (
    steady && mode[1] |-> !serial_data_in_o && !serial_clock_pin_o &&
    (dir[PIN_DI] || serial_data_in_oe_n_o) && (dir[PIN_CK] || serial_clock_pin_oe_n_o))
    else $error("two-wire line driven high or without its direction bit");
  AST_TWO_SDA_PORT_LOW: assert property (
    steady && mode[1] && dir[PIN_DI] && !port[PIN_DI] |-> !serial_data_in_oe_n_o)
    else $error("data line not pulled low by port bit");
  AST_TWO_SCL_PORT_LOW: assert property (
    steady && mode[1] && dir[PIN_CK] && !port[PIN_CK] |-> !serial_clock_pin_oe_n_o)
    else $error("clock line not pulled low by port bit");
endmodule : serial_mode_clock_select_asserts
bind serial_mode_clock_select serial_mode_clock_select_asserts chk_u (.*);
`default_nettype wire

// ==== bench/serial_peer_model.sv ====
// Far-side peer on the serial lines, with bus pull-ups on both wires.
`default_nettype none
module serial_peer_model (
  input wire logic sda_o_i,
  input wire logic sda_oe_n_i,
  input wire logic scl_o_i,
  input wire logic scl_oe_n_i,
  output logic sda_line_o,
  output logic scl_line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic peer_sda = 1'b1;
  logic peer_scl = 1'b1;
  // Wired-AND: a released line goes high, any party may pull it low.
  assign sda_line_o = peer_sda && (sda_oe_n_i || sda_o_i);
  assign scl_line_o = peer_scl && (scl_oe_n_i || scl_o_i);
  // The clock runs only inside a frame and rests high between frames.
  task automatic clock_frame(input int n);
    repeat (n) begin
      #80;
      // Deferred, so an edge that lands on a core clock edge never races its sampling.
      peer_scl <= !peer_scl;
    end
  endtask : clock_frame
  task automatic start_cond();
    peer_sda = 1'b0;
    #400;
    peer_sda = 1'b1;
  endtask : start_cond
endmodule : serial_peer_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench for the serial wire-mode and clock-select block.
`default_nettype none
module tb_top
  import serial_mode_clock_select_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, wr_s, rd_s, tmr, sda, scl;
  logic [2:0] addr;
  logic [7:0] wdata, rdata;
  logic do_o, do_oe_n, do_pu, di_o, di_oe_n, di_pu, ck_o, ck_oe_n, ck_pu;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  serial_mode_clock_select dut (.core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
    .timer0_match_i(tmr), .serial_data_in_i(sda), .serial_clock_pin_i(scl),
    .data_out_pin_o(do_o), .data_out_pin_oe_n_o(do_oe_n), .data_out_pin_pullup_o(do_pu),
    .serial_data_in_o(di_o), .serial_data_in_oe_n_o(di_oe_n),
    .serial_data_in_pullup_o(di_pu), .serial_clock_pin_o(ck_o),
    .serial_clock_pin_oe_n_o(ck_oe_n), .serial_clock_pin_pullup_o(ck_pu));
  serial_peer_model peer (.sda_o_i(di_o), .sda_oe_n_i(di_oe_n), .scl_o_i(ck_o),
    .scl_oe_n_i(ck_oe_n), .sda_line_o(sda), .scl_line_o(scl));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic tally_and_finish();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk(rdata & m, e);
  endtask : rchk
  // Pins are registered one edge behind the state, so a few edges settle them.
  task automatic settle();
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask : settle
  task automatic timer_pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      tmr <= 1'b1;
      @(posedge clk);
      tmr <= 1'b0;
    end
  endtask : timer_pulses
  task automatic t_sw_strobe();
    wr(DIR_ADDR, 8'h01);
    wr(DATA_ADDR, 8'h40);
    wr(CTRL_ADDR, 8'h10);
    settle();
    chk({7'h00, do_o}, 8'h00);
    wr(CTRL_ADDR, 8'h12);
    settle();
    chk({7'h00, do_o}, 8'h01);
    rchk(DATA_ADDR, 8'h81, 8'hff);
    rchk(STAT_ADDR, 8'h01, 8'hff);
    rchk(CTRL_ADDR, 8'h10, 8'hff);
    wr(STAT_ADDR, 8'h0f);
    wr(CTRL_ADDR, 8'h12);
    rchk(STAT_ADDR, 8'h40, 8'hff);
    wr(STAT_ADDR, 8'h40);
    rchk(STAT_ADDR, 8'h00, 8'hff);
  endtask : t_sw_strobe
  task automatic t_timer();
    wr(CTRL_ADDR, 8'h14);
    timer_pulses(3);
    rchk(STAT_ADDR, 8'h03, 8'hff);
    wr(CTRL_ADDR, 8'h10);
    timer_pulses(2);
    rchk(STAT_ADDR, 8'h03, 8'hff);
  endtask : t_timer
  task automatic t_external();
    wr(STAT_ADDR, 8'hc0);
    wr(CTRL_ADDR, 8'h08);
    peer.clock_frame(8);
    repeat (6) @(posedge clk);
    rchk(STAT_ADDR, 8'h08, 8'hff);
    wr(CTRL_ADDR, 8'h0a);
    wr(CTRL_ADDR, 8'h0b);
    rchk(PORT_ADDR, 8'h04, 8'hff);
    rchk(STAT_ADDR, 8'h09, 8'hff);
    rchk(CTRL_ADDR, 8'h08, 8'hff);
  endtask : t_external
  // Three-wire master: toggle writes clock the pin, the pin clocks the shift
  // register through the peer, and toggle writes alone feed the counter.
  task automatic t_three_master();
    wr(STAT_ADDR, 8'hc0);
    wr(PORT_ADDR, 8'h00);
    wr(DATA_ADDR, 8'h80);
    wr(CTRL_ADDR, 8'h1a);
    wr(DIR_ADDR, 8'h05);
    settle();
    settle();
    chk({7'h00, do_o}, 8'h01);
    wr(STAT_ADDR, 8'hc0);
    wr(CTRL_ADDR, 8'h1b);
    settle();
    settle();
    chk({6'h00, ck_o, ck_oe_n}, 8'h02);
    chk({7'h00, do_o}, 8'h01);
    rchk(DATA_ADDR, 8'h01, 8'hff);
    wr(CTRL_ADDR, 8'h1b);
    settle();
    settle();
    chk({7'h00, do_o}, 8'h00);
    rchk(STAT_ADDR, 8'h82, 8'hff);
    wr(CTRL_ADDR, 8'h00);
    wr(DIR_ADDR, 8'h00);
    wr(STAT_ADDR, 8'hc0);
  endtask : t_three_master
  task automatic t_two_wire();
    wr(DATA_ADDR, 8'hff);
    wr(PORT_ADDR, 8'h06);
    wr(CTRL_ADDR, 8'h20);
    wr(STAT_ADDR, 8'hc0);
    wr(DIR_ADDR, 8'h06);
    settle();
    chk({6'h00, ck_oe_n, di_oe_n}, 8'h03);
    peer.start_cond();
    settle();
    rchk(STAT_ADDR, 8'h80, 8'h80);
    chk({7'h00, ck_oe_n}, 8'h00);
    wr(STAT_ADDR, 8'h80);
    settle();
    chk({7'h00, ck_oe_n}, 8'h01);
    wr(CTRL_ADDR, 8'h30);
    wr(STAT_ADDR, 8'h0f);
    wr(CTRL_ADDR, 8'h32);
    settle();
    chk({7'h00, ck_oe_n}, 8'h00);
    wr(STAT_ADDR, 8'h40);
    settle();
    chk({7'h00, ck_oe_n}, 8'h01);
    wr(PORT_ADDR, 8'h00);
    settle();
    chk({6'h00, ck_oe_n, di_oe_n}, 8'h00);
  endtask : t_two_wire
  initial begin
    rst = 1'b1;
    wr_s = 1'b0;
    rd_s = 1'b0;
    tmr = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rchk(CTRL_ADDR, 8'h00, 8'hff);
    t_sw_strobe();
    t_timer();
    t_external();
    t_three_master();
    t_two_wire();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
